// *** src/bfl_pkg.sv ***
// Constants for the buck fault and light-load controller
// Notes on behaviour
// - Default or analog setup enters hiccup after eight current-limited cycles.
// - Six consecutive trip-free cycles clear the overcurrent cycle counter.
// - Hiccup drops conversion enable and holds it low for 20 ms.
// - After each hiccup, trip state resets and conversion restarts; repeats.
// - Response: limit for 8 to 64 cycles, then latch off or hiccup.
// - Trip while duty is below one eighth adds no duty ceiling.
// - Three consecutive trip cycles lower the ceiling: half, quarter, eighth.
// - At one eighth, keep switching until count reaches maximum, then stop.
// - Four consecutive clean cycles double the ceiling back to unlimited.
// - Die temperature is reported at one degree per bit.
// - Default trip at 145 C; exceeding it drops conversion enable.
// - Auto-restart resumes only 25 C below the trip threshold.
// - Threshold and response are settable: ignore, auto-restart or latch.
// - Light-load mode enabled by command in digital mode, pin in analog.
// - After reference ramp, error-amp level is sampled before light load.
// - Enter adaptive on-time after zero crossings in eight consecutive cycles.
// - Fixed pulse, low side until zero, both off until sense reaches ref.
// - Leave light load at 95 percent or three low zero-cross events.
// - Tracking mode inhibits adaptive on-time operation.
// - Voltage change disables light load until ramp done and resampled.
// - Comparator sampled once per cycle in 75 ns after set pulse.
package bfl_pkg;
  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_OT_LIM  = 8'h04;
  localparam logic [7:0] ADR_STATUS  = 8'h08;
  localparam logic [7:0] ADR_TEMP    = 8'h0C;
  localparam logic [7:0] ADR_CAL     = 8'h10;
  localparam int CTL_DIG    = 0;
  localparam int CTL_LLCMD  = 1;
  localparam int CTL_OCLAT  = 2;
  localparam int CTL_OCN    = 4;
  localparam int CTL_OTR    = 8;
  localparam int CTL_CLR    = 16;
  localparam logic [9:0] CTL_RST = 10'h100;
  localparam logic [1:0] OTR_IGN  = 2'h0;
  localparam logic [1:0] OTR_AUTO = 2'h1;
  localparam logic [1:0] OTR_LAT  = 2'h2;
  localparam logic [7:0] OT_DEF   = 8'h91;
  localparam logic [8:0] OT_HYST  = 9'h019;
  // ****************************************************************
  // Counts and timing
  // ****************************************************************
  localparam logic [6:0] OC_BASE  = 7'h08;
  localparam logic [2:0] OC_CLEAN = 3'h6;
  localparam logic [1:0] CC_DOWN  = 2'h3;
  localparam logic [2:0] CC_UP    = 3'h4;
  localparam logic [3:0] ZC_ENTRY = 4'h8;
  localparam logic [1:0] AOT_EXIT = 2'h3;
  localparam int CLK_HZ      = 100_000_000;
  localparam int CLK_NS      = 10;
  localparam int HICCUP_MS   = 20;
  localparam int HICCUP_CYC  = HICCUP_MS * (CLK_HZ / 1000);
  localparam int OC_WIN_NS   = 75;
  localparam logic [3:0] OC_WIN_CYC = 4'(OC_WIN_NS / CLK_NS);
  typedef enum logic [1:0] {
    ST_RUN = 2'h0, ST_HIC = 2'h1, ST_LAT = 2'h3, ST_OT = 2'h2
  } bfl_st_t;
  typedef enum logic [1:0] {
    AP_WAIT = 2'h0, AP_HI = 2'h1, AP_LO = 2'h3
  } bfl_ap_t;
endpackage

// *** src/bfl_ctrl.sv ***
// Buck fault supervision and light-load control with Wishbone slave
`timescale 1ns/10ps
module bfl_ctrl #(
  parameter int HIC_CYC = bfl_pkg::HICCUP_CYC,
  parameter int ON_CYC  = 20
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic             o_wb_ack,
  output logic      [31:0] o_wb_dat,
  input  wire logic        i_set_pulse,
  input  wire logic        i_oc_cmp,
  input  wire logic        i_zero_cross,
  input  wire logic        i_vsns_below_ref,
  input  wire logic        i_vout_below_95,
  input  wire logic        i_light_load_enable_pin,
  input  wire logic        i_track_mode,
  input  wire logic        i_duty_below_eighth,
  input  wire logic [7:0]  i_temp_c,
  input  wire logic        i_ref_ramp_done,
  input  wire logic        i_vout_change,
  input  wire logic        i_cal_ack,
  input  wire logic [7:0]  i_comp_code,
  output logic             o_conv_en,
  output logic      [1:0]  o_duty_ceiling,
  output logic             o_adaptive_on_time_mode,
  output logic             o_high_side_drive,
  output logic             o_low_side_drive,
  output logic             o_cal_req,
  output logic      [7:0]  o_cal_dac_code,
  output logic             o_fault_alert_line_n
);
  // ****************************************************************
  // Parameter checks and state
  // ****************************************************************
  if (HIC_CYC < 2 || HIC_CYC > 16777215) begin : g_bad_hic
    $error("HIC_CYC out of range");
  end
  if (ON_CYC < 1 || ON_CYC > 255) begin : g_bad_on
    $error("ON_CYC out of range");
  end

  typedef struct packed {
    bfl_pkg::bfl_st_t st;
    bfl_pkg::bfl_ap_t ap;
    logic [6:0]  sync1;
    logic [6:0]  sync2;
    logic        set_prev;
    logic        zc_prev;
    logic [3:0]  win;
    logic        win_oc;
    logic [23:0] hic;
    logic [6:0]  oc_tot;
    logic [2:0]  clean;
    logic [1:0]  oc_run;
    logic [2:0]  ok_run;
    logic [1:0]  duty;
    logic        zc_seen;
    logic [3:0]  zc_run;
    logic        adaptive_on_time_mode;
    logic [1:0]  low_zc;
    logic [7:0]  on_cnt;
    logic        cal_valid;
    logic [7:0]  cal_code;
    logic        cal_req;
    logic        ramp_prev;
    logic [9:0]  ctl;
    logic [7:0]  ot_lim;
    logic        oc_flag;
    logic        ot_flag;
    logic        ack;
    logic [31:0] dat;
  } bfl_state_t;

  bfl_state_t r;
  bfl_state_t n;

  // Synchronised pin levels
  logic       s_set;
  logic       s_oc;
  logic       s_zc;
  logic       s_below;
  logic       s_uv95;
  logic       s_llpin;
  logic       s_track;
  assign {s_track, s_llpin, s_uv95, s_below, s_zc, s_oc, s_set} = r.sync2;

  logic       dig;
  logic       ll_en;
  logic [1:0] ot_resp;
  logic [7:0] ot_thr;
  logic [6:0] oc_lim;
  logic       cyc_ev;
  logic       oc_hit;
  logic       oc_set;
  logic       zc_rise;
  logic       ot_over;
  logic       ot_cool;
  logic       wb_go;
  logic       wr_ctl;
  logic       allow;

  always_comb begin
    dig     = r.ctl[bfl_pkg::CTL_DIG];
    ll_en   = dig ? r.ctl[bfl_pkg::CTL_LLCMD] : s_llpin;
    ot_resp = dig ? r.ctl[bfl_pkg::CTL_OTR +: 2] : bfl_pkg::OTR_AUTO;
    ot_thr  = dig ? r.ot_lim : bfl_pkg::OT_DEF;
    oc_lim  = dig ? {({1'b0, r.ctl[bfl_pkg::CTL_OCN +: 3]} + 4'h1), 3'h0}
                  : bfl_pkg::OC_BASE;
    cyc_ev  = (r.win == bfl_pkg::OC_WIN_CYC);
    oc_hit  = r.win_oc | s_oc;
    oc_set  = cyc_ev & oc_hit & (r.st == bfl_pkg::ST_RUN)
              & (r.oc_tot + 7'h1 >= oc_lim);
    zc_rise = s_zc & ~r.zc_prev;
    ot_over = (ot_resp != bfl_pkg::OTR_IGN) && (i_temp_c > ot_thr);
    ot_cool = ({1'b0, i_temp_c} + bfl_pkg::OT_HYST) <= {1'b0, ot_thr};
    wb_go   = i_wb_cyc & i_wb_stb & ~r.ack;
    wr_ctl  = wb_go & i_wb_we & (i_wb_adr == bfl_pkg::ADR_CTRL);
    allow   = ll_en & ~s_track & r.cal_valid & (r.st == bfl_pkg::ST_RUN);
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    n = r;
    n.sync1    = {i_track_mode, i_light_load_enable_pin, i_vout_below_95,
                  i_vsns_below_ref, i_zero_cross, i_oc_cmp, i_set_pulse};
    n.sync2    = r.sync1;
    n.set_prev = s_set;
    n.zc_prev  = s_zc;
    n.cal_req  = 1'b0;
    n.ack      = wb_go;

    // Comparator window opens at the set pulse edge
    if (s_set && !r.set_prev) begin
      n.win    = 4'h1;
      n.win_oc = 1'b0;
    end else if (r.win != 4'h0 && !cyc_ev) begin
      n.win    = r.win + 4'h1;
      n.win_oc = r.win_oc | s_oc;
    end else if (cyc_ev) begin
      n.win    = 4'h0;
    end

    // Overcurrent counting once per switching cycle
    if (cyc_ev && r.st == bfl_pkg::ST_RUN) begin
      if (oc_hit) begin
        n.oc_tot = (r.oc_tot == 7'h7F) ? r.oc_tot : r.oc_tot + 7'h1;
        n.clean  = 3'h0;
        n.ok_run = 3'h0;
        n.oc_run = r.oc_run + 2'h1;
        if (r.oc_run == bfl_pkg::CC_DOWN - 2'h1) begin
          n.oc_run = 2'h0;
          if (!(r.duty == 2'h0 && i_duty_below_eighth)
              && r.duty != 2'h3) begin
            n.duty = r.duty + 2'h1;
          end
        end
        if (oc_set) begin
          n.oc_flag = 1'b1;
          n.st = (dig && r.ctl[bfl_pkg::CTL_OCLAT]) ? bfl_pkg::ST_LAT
                                                    : bfl_pkg::ST_HIC;
        end
      end else begin
        n.oc_run = 2'h0;
        n.clean  = r.clean + 3'h1;
        if (r.clean == bfl_pkg::OC_CLEAN - 3'h1) begin
          n.clean  = 3'h0;
          n.oc_tot = 7'h0;
        end
        n.ok_run = r.ok_run + 3'h1;
        if (r.ok_run == bfl_pkg::CC_UP - 3'h1) begin
          n.ok_run = 3'h0;
          if (r.duty != 2'h0) begin
            n.duty = r.duty - 2'h1;
          end
        end
      end
    end

    // Shutdown states and their exits
    case (r.st)
      bfl_pkg::ST_HIC: begin
        n.hic = r.hic + 24'h1;
        if (r.hic == 24'(HIC_CYC - 1)) begin
          n.st = bfl_pkg::ST_RUN;
        end
      end
      bfl_pkg::ST_OT: begin
        if (ot_cool || ot_resp == bfl_pkg::OTR_IGN) begin
          n.st = bfl_pkg::ST_RUN;
        end
      end
      bfl_pkg::ST_LAT: begin
        if (wr_ctl && i_wb_sel[2] && i_wb_dat[bfl_pkg::CTL_CLR]) begin
          n.st = bfl_pkg::ST_RUN;
        end
      end
      default: ;
    endcase

    // Temperature response overrides overcurrent
    if (ot_over && r.st != bfl_pkg::ST_LAT) begin
      n.ot_flag = 1'b1;
      n.st = (ot_resp == bfl_pkg::OTR_LAT) ? bfl_pkg::ST_LAT
                                           : bfl_pkg::ST_OT;
    end

    // Counters restart whenever conversion is off
    if (r.st != bfl_pkg::ST_RUN) begin
      n.oc_tot = 7'h0;
      n.clean  = 3'h0;
      n.oc_run = 2'h0;
      n.ok_run = 3'h0;
      n.duty   = 2'h0;
      n.zc_run = 4'h0;
    end
    if (r.st != bfl_pkg::ST_HIC) begin
      n.hic = 24'h0;
    end

    // Calibration of the error-amp level
    n.ramp_prev = i_ref_ramp_done;
    if (i_ref_ramp_done && !r.ramp_prev) begin
      n.cal_req = 1'b1;
    end
    if (i_cal_ack) begin
      n.cal_valid = 1'b1;
      n.cal_code  = i_comp_code;
    end
    if (i_vout_change) begin
      n.cal_valid = 1'b0;
    end

    // Light-load entry and exit
    if (zc_rise) begin
      n.zc_seen = 1'b1;
    end
    if (cyc_ev) begin
      n.zc_seen = zc_rise;
      if (!r.adaptive_on_time_mode) begin
        n.zc_run = r.zc_seen ? r.zc_run + 4'h1 : 4'h0;
        if (r.zc_seen && r.zc_run == bfl_pkg::ZC_ENTRY - 4'h1) begin
          n.adaptive_on_time_mode    = 1'b1;
          n.zc_run = 4'h0;
        end
      end
    end
    if (r.adaptive_on_time_mode) begin
      if (zc_rise) begin
        n.low_zc = s_below ? r.low_zc + 2'h1 : 2'h0;
        if (s_below && r.low_zc == bfl_pkg::AOT_EXIT - 2'h1) begin
          n.adaptive_on_time_mode = 1'b0;
        end
      end
      if (s_uv95) begin
        n.adaptive_on_time_mode = 1'b0;
      end
    end
    if (!allow) begin
      n.adaptive_on_time_mode    = 1'b0;
      n.zc_run = 4'h0;
    end
    if (!n.adaptive_on_time_mode) begin
      n.low_zc = 2'h0;
    end

    // Fixed pulse, diode emulation, wait for sense
    case (r.ap)
      bfl_pkg::AP_WAIT: begin
        if (r.adaptive_on_time_mode && s_below && s_zc) begin
          n.ap     = bfl_pkg::AP_HI;
          n.on_cnt = 8'h0;
        end
      end
      bfl_pkg::AP_HI: begin
        n.on_cnt = r.on_cnt + 8'h1;
        if (r.on_cnt == 8'(ON_CYC - 1)) begin
          n.ap = bfl_pkg::AP_LO;
        end
      end
      bfl_pkg::AP_LO: begin
        if (s_zc) begin
          n.ap = bfl_pkg::AP_WAIT;
        end
      end
      default: n.ap = bfl_pkg::AP_WAIT;
    endcase
    if (!r.adaptive_on_time_mode) begin
      n.ap = bfl_pkg::AP_WAIT;
    end

    // Register access
    n.dat = 32'h0;
    if (wb_go && i_wb_we) begin
      case (i_wb_adr)
        bfl_pkg::ADR_CTRL: begin
          if (i_wb_sel[0]) n.ctl[7:0] = i_wb_dat[7:0];
          if (i_wb_sel[1]) n.ctl[9:8] = i_wb_dat[9:8];
        end
        bfl_pkg::ADR_OT_LIM: begin
          if (i_wb_sel[0]) n.ot_lim = i_wb_dat[7:0];
        end
        bfl_pkg::ADR_STATUS: begin // Clear faults, set wins
          if (i_wb_sel[1] && i_wb_dat[8]) n.oc_flag = oc_set;
          if (i_wb_sel[1] && i_wb_dat[9]) n.ot_flag = ot_over;
        end
        default: ;
      endcase
    end else if (wb_go) begin
      case (i_wb_adr)
        bfl_pkg::ADR_CTRL:   n.dat = {22'h0, r.ctl};
        bfl_pkg::ADR_OT_LIM: n.dat = {24'h0, r.ot_lim};
        bfl_pkg::ADR_STATUS: n.dat = {4'h0, r.oc_tot, r.zc_run, 1'b0, r.ap,
                                      r.duty, r.cal_valid, r.adaptive_on_time_mode,
                                      r.ot_flag, r.oc_flag, 6'h0, r.st};
        bfl_pkg::ADR_TEMP:   n.dat = {24'h0, i_temp_c};
        bfl_pkg::ADR_CAL:    n.dat = {24'h0, r.cal_code};
        default:             n.dat = 32'h0;
      endcase
    end

    if (i_srst) begin
      n        = '0;
      n.st     = bfl_pkg::ST_RUN;
      n.ap     = bfl_pkg::AP_WAIT;
      n.ctl    = bfl_pkg::CTL_RST;
      n.ot_lim = bfl_pkg::OT_DEF;
    end
  end

  always_ff @(posedge i_core_clk) begin
    r <= n;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_wb_ack                = r.ack;
  assign o_wb_dat                = r.dat;
  assign o_conv_en               = (r.st == bfl_pkg::ST_RUN);
  assign o_duty_ceiling          = r.duty;
  assign o_adaptive_on_time_mode = r.adaptive_on_time_mode;
  assign o_high_side_drive       = r.adaptive_on_time_mode && r.ap == bfl_pkg::AP_HI;
  assign o_low_side_drive        = r.adaptive_on_time_mode && r.ap == bfl_pkg::AP_LO;
  assign o_cal_req               = r.cal_req;
  assign o_cal_dac_code          = r.cal_code;
  assign o_fault_alert_line_n    = ~(r.oc_flag | r.ot_flag);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  property p_oc_stop;
    cyc_ev && oc_hit && r.st == bfl_pkg::ST_RUN && !ot_over
      && r.oc_tot + 7'h1 >= oc_lim |=> !o_conv_en ##0 r.oc_flag;
  endproperty
  a_oc_stop: assert property (p_oc_stop)
    else $error("overcurrent limit did not stop conversion");

  property p_hic_low;
    $rose(r.st == bfl_pkg::ST_HIC) |-> !o_conv_en [*8];
  endproperty
  a_hic_low: assert property (p_hic_low)
    else $error("hiccup released enable too early");

  property p_hic_end;
    r.st == bfl_pkg::ST_HIC && r.hic == 24'(HIC_CYC - 1) && !ot_over
      |=> o_conv_en && r.oc_tot == 7'h0;
  endproperty
  a_hic_end: assert property (p_hic_end)
    else $error("hiccup did not restart with cleared count");

  property p_clean;
    cyc_ev && !oc_hit && r.st == bfl_pkg::ST_RUN && r.clean == 3'h5
      |=> r.oc_tot == 7'h0;
  endproperty
  a_clean: assert property (p_clean)
    else $error("clean run did not clear the count");

  property p_step;
    cyc_ev && oc_hit && r.st == bfl_pkg::ST_RUN && r.oc_run == 2'h2
      && !i_duty_below_eighth && r.duty != 2'h3 && !ot_over
      |=> r.duty == $past(r.duty) + 2'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("duty ceiling did not step down");

  property p_ot_hold;
    r.st == bfl_pkg::ST_OT && !ot_cool && ot_resp == bfl_pkg::OTR_AUTO
      |=> !o_conv_en;
  endproperty
  a_ot_hold: assert property (p_ot_hold)
    else $error("restart inside temperature hysteresis");

  property p_latch;
    r.st == bfl_pkg::ST_LAT && !wr_ctl |=> r.st == bfl_pkg::ST_LAT;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched shutdown left without control action");

  property p_aot_in;
    $rose(r.adaptive_on_time_mode) |-> $past(r.zc_run) == 4'h7 && r.cal_valid;
  endproperty
  a_aot_in: assert property (p_aot_in)
    else $error("light-load entry without eight crossings");

  property p_track;
    s_track || i_vout_change |=> !r.adaptive_on_time_mode;
  endproperty
  a_track: assert property (p_track)
    else $error("light-load active while inhibited");

  c_hiccup: cover property ($rose(r.st == bfl_pkg::ST_HIC));
  c_eighth: cover property (r.duty == 2'h3);
  c_aot:    cover property ($rose(r.adaptive_on_time_mode) ##[1:50] o_high_side_drive);
  c_ot:     cover property ($fell(r.st == bfl_pkg::ST_OT));
endmodule

// *** tb/bfl_stage_model.sv ***
// Power stage and analog comparator model facing the fault controller
`timescale 1ns/10ps
module bfl_stage_model #(
  parameter logic [7:0] CODE = 8'h5A
) (
  input  wire logic       i_clk,
  input  wire logic       i_conv_en,
  input  wire logic       i_overload,
  input  wire logic       i_light,
  input  wire logic       i_cal_req,
  output logic            o_set_pulse,
  output logic            o_oc_cmp,
  output logic            o_zero_cross,
  output logic            o_vsns_below_ref,
  output logic            o_cal_ack,
  output logic      [7:0] o_comp_code
);
  logic [3:0] phase = 4'h0;
  logic [2:0] cal_dly = 3'h0;
  logic       en_ok;
  // Enable counts only when known, so the phase never goes unknown
  assign en_ok = (i_conv_en === 1'h1);
  // Stage stops switching while conversion is disabled
  always_ff @(posedge i_clk) begin
    phase <= (phase == 4'hB || !en_ok) ? 4'h0 : phase + 4'h1;
    o_set_pulse <= en_ok && phase < 4'h2;
    // Trip level taken as a host setting of 16 A or more, step of four
    o_oc_cmp <= en_ok && i_overload;
    o_zero_cross <= en_ok && i_light && phase > 4'h5;
    o_vsns_below_ref <= !i_light || phase == 4'hB;
    cal_dly <= i_cal_req ? 3'h3 : (cal_dly != 3'h0 ? cal_dly - 3'h1 : 3'h0);
    o_cal_ack <= cal_dly == 3'h1;
    o_comp_code <= cal_dly == 3'h1 ? CODE : ~CODE;
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the buck fault and light-load controller
`timescale 1ns/10ps
module testbench;
  localparam int HIC = 50;
  localparam int ON  = 20;
  logic        clk, srst, cyc, stb, we, ack, setp, occ, zc, vsb, calr;
  logic        cala, lpin, trk, dbe, rdone, vchg, b95, en, adaptive_on_time_mode, aln;
  logic        ovl, lit, hsd, lsd;
  logic [7:0]  adr, temp, code, dac;
  logic [31:0] wdat, rdat, q;
  logic [1:0]  duty;
  int          fail_count, num_checks, cycles, n;

  bfl_ctrl #(.HIC_CYC(HIC), .ON_CYC(ON)) u_dut (
    .i_core_clk(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_ack(ack), .o_wb_dat(rdat), .i_set_pulse(setp), .i_oc_cmp(occ),
    .i_zero_cross(zc), .i_vsns_below_ref(vsb), .i_vout_below_95(b95),
    .i_light_load_enable_pin(lpin), .i_track_mode(trk),
    .i_duty_below_eighth(dbe), .i_temp_c(temp), .i_ref_ramp_done(rdone),
    .i_vout_change(vchg), .i_cal_ack(cala), .i_comp_code(code),
    .o_conv_en(en), .o_duty_ceiling(duty), .o_adaptive_on_time_mode(adaptive_on_time_mode),
    .o_high_side_drive(hsd), .o_low_side_drive(lsd), .o_cal_req(calr),
    .o_cal_dac_code(dac), .o_fault_alert_line_n(aln));

  bfl_stage_model u_stage (
    .i_clk(clk), .i_conv_en(en), .i_overload(ovl), .i_light(lit),
    .i_cal_req(calr), .o_set_pulse(setp), .o_oc_cmp(occ),
    .o_zero_cross(zc), .o_vsns_below_ref(vsb), .o_cal_ack(cala),
    .o_comp_code(code));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  initial clk = 1'h0;
  always #5 clk = ~clk;

  task automatic conclude;
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'h1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    chk("ack", 32'h1, {31'h0, ack});
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask

  // Lets the switching cycle in progress finish so counts start clean
  task automatic align;
    @(posedge setp);
    repeat (11) @(posedge clk);
  endtask

  // Runs k switching cycles with the overload level given
  task automatic sw(input logic o, input int k);
    ovl <= o;
    repeat (k) begin
      @(posedge setp);
      repeat (11) @(posedge clk);
    end
  endtask

  task automatic till(input logic v);
    n = 0;
    while (en !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    wb(1'h0, bfl_pkg::ADR_CTRL, 32'h0);
    chk("ctrl", {22'h0, bfl_pkg::CTL_RST}, q);
    wb(1'h0, bfl_pkg::ADR_OT_LIM, 32'h0);
    chk("ot_lim", {24'h0, bfl_pkg::OT_DEF}, q);
    wb(1'h0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1'h1, bfl_pkg::ADR_STATUS, 32'h300);
    chk("alert_n", 32'h1, {31'h0, aln});
  endtask

  task automatic t_hiccup;
    align();
    dbe <= 1'h1;
    sw(1'h1, 7);
    chk("en7", 32'h1, {31'h0, en});
    chk("duty_low", 32'h0, {30'h0, duty});
    sw(1'h1, 1);
    till(1'h0);
    chk("en8", 32'h0, {31'h0, en});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (en !== 1'h1 && n < 400);
    chk("hic_len", HIC, n);
    sw(1'h1, 8);
    till(1'h0);
    chk("rehic", 32'h0, {31'h0, en});
    ovl <= 1'h0;
    till(1'h1);
    dbe <= 1'h0;
  endtask

  task automatic t_limit;
    sw(1'h1, 5);
    chk("half", 32'h1, {30'h0, duty});
    sw(1'h0, 4);
    chk("up", 32'h0, {30'h0, duty});
    sw(1'h0, 2);
    sw(1'h1, 7);
    chk("clean_clr", 32'h1, {31'h0, en});
    chk("quarter", 32'h2, {30'h0, duty});
    sw(1'h0, 4);
    chk("up_q", 32'h1, {30'h0, duty});
    sw(1'h0, 4);
  endtask

  task automatic t_latch;
    wb(1'h1, bfl_pkg::ADR_CTRL, 32'h115);
    align();
    for (int k = 1; k < 4; k++) begin
      sw(1'h1, 3);
      chk("step", k, {30'h0, duty});
    end
    sw(1'h1, 6);
    chk("at_eighth", 32'h1, {31'h0, en});
    sw(1'h1, 1);
    till(1'h0);
    chk("max16", 32'h0, {31'h0, en});
    ovl <= 1'h0;
    repeat (3 * HIC) @(posedge clk);
    chk("latched", 32'h0, {31'h0, en});
    wb(1'h0, bfl_pkg::ADR_STATUS, 32'h0);
    chk("state", 32'h3, {30'h0, q[1:0]});
    chk("oc_flag", 32'h1, {31'h0, q[8]});
    wb(1'h1, bfl_pkg::ADR_CTRL, 32'h10115);
    till(1'h1);
    chk("unlatch", 32'h1, {31'h0, en});
  endtask

  task automatic t_temp;
    temp <= 8'h91;
    repeat (20) @(posedge clk);
    chk("ot_eq", 32'h1, {31'h0, en});
    temp <= 8'h92;
    till(1'h0);
    chk("ot_trip", 32'h0, {31'h0, en});
    wb(1'h0, bfl_pkg::ADR_TEMP, 32'h0);
    chk("temp", 32'h92, q);
    temp <= 8'h79;
    repeat (20) @(posedge clk);
    chk("hyst", 32'h0, {31'h0, en});
    temp <= 8'h78;
    till(1'h1);
    chk("restart", 32'h1, {31'h0, en});
    chk("alert_set", 32'h0, {31'h0, aln});
    wb(1'h1, bfl_pkg::ADR_STATUS, 32'h300);
    chk("alert_clr", 32'h1, {31'h0, aln});
    temp <= 8'h64;
    wb(1'h1, bfl_pkg::ADR_OT_LIM, 32'h64);
    wb(1'h1, bfl_pkg::ADR_CTRL, 32'h215);
    chk("lim_eq", 32'h1, {31'h0, en});
    temp <= 8'h65;
    till(1'h0);
    chk("new_lim", 32'h0, {31'h0, en});
    temp <= 8'h20;
    repeat (20) @(posedge clk);
    chk("ot_latch", 32'h0, {31'h0, en});
    wb(1'h1, bfl_pkg::ADR_CTRL, 32'h10015);
    temp <= 8'hC8;
    repeat (20) @(posedge clk);
    chk("ignore", 32'h1, {31'h0, en});
    temp <= 8'h19;
  endtask

  task automatic t_light;
    wb(1'h1, bfl_pkg::ADR_CTRL, 32'h3);
    rdone <= 1'h1;
    repeat (10) @(posedge clk);
    chk("cal", 32'h5A, {24'h0, dac});
    align();
    lit <= 1'h1;
    sw(1'h0, 7);
    chk("zc7", 32'h0, {31'h0, adaptive_on_time_mode});
    sw(1'h0, 1);
    chk("zc8", 32'h1, {31'h0, adaptive_on_time_mode});
    n = 0;
    while (hsd !== 1'h1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("hs_on", 32'h1, {31'h0, hsd});
    chk("ls_off", 32'h0, {31'h0, lsd});
    repeat (ON) @(posedge clk);
    chk("hs_off", 32'h0, {31'h0, hsd});
    chk("ls_on", 32'h1, {31'h0, lsd});
    b95 <= 1'h1;
    repeat (6) @(posedge clk);
    chk("exit95", 32'h0, {31'h0, adaptive_on_time_mode});
    b95 <= 1'h0;
    trk <= 1'h1;
    sw(1'h0, 10);
    chk("track", 32'h0, {31'h0, adaptive_on_time_mode});
    trk <= 1'h0;
    vchg <= 1'h1;
    @(posedge clk);
    vchg <= 1'h0;
    sw(1'h0, 10);
    chk("vchg", 32'h0, {31'h0, adaptive_on_time_mode});
    rdone <= 1'h0;
    @(posedge clk);
    rdone <= 1'h1;
    sw(1'h0, 9);
    chk("recal", 32'h1, {31'h0, adaptive_on_time_mode});
  endtask

  initial begin
    srst = 1'h1;
    {cyc, stb, we, ovl, lit, lpin, trk, dbe, rdone, vchg, b95} = 11'h0;
    adr = 8'h00;
    wdat = 32'h0;
    temp = 8'h19;
    fail_count = 0;
    num_checks = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    srst <= 1'h0;
    repeat (3) @(posedge clk);
    t_regs();
    t_hiccup();
    t_limit();
    t_latch();
    t_temp();
    t_light();
    conclude();
  end
endmodule
